// [dso_pkg.sv]
// Notes on behaviour
// - Code 4: closed at or below level 1, reopens at level 1 plus width 1.
// - Code 5: closed at or above level 1, releases at level 1 minus width 1.
// - Codes 4 and 5 compare frequency magnitude, same in either direction.
// - Code 15: low detector like code 4 using level 2 and width 2.
// - Code 16: high detector like code 5 using level 2 and width 2.
// - Codes 14, 15, 16 respond only in the direction signed into level 2.
// - Code 6: closed with no major or keypad fault and no editing, or running under the option.
// - Code 7: closed on bus or control undervoltage or open soft-charge feedback.
// - Code 8: closed while output firing is inhibited by baseblock.
// - Code 9 closed for keypad reference, code A for keypad run command.
// - Code B: closed after current deviates from torque level for torque time.
// - Code 17: normally closed, opens after current deviates from torque level for torque time.
// - Code C: closed when analog reference drops 90 percent within 0.4 s.
// - Code D: closed on braking resistor overheat or braking transistor fault.
// - Code E: closed on any major fault except the two keypad faults.
// - Code F: output disabled whatever the drive does.
// - Code 10: closed on minor fault; alarms never close major fault outputs.
// - Code 11: closed while a fault reset is being attempted.
// - Code 12: closes after timer input stays closed for the on delay.
// - Code 12: opens after timer input stays open for the off delay.
// - Code 13: closed while frequency is within width 2 of the reference.
// - Code 14: closed while frequency and reference lie near level 2.
package dso_pkg;
  // ****************************************
  // Sizes and offsets
  // ****************************************
  localparam int unsigned NUM_OUT = 3;
  localparam int unsigned ADDR_W = 6;
  localparam logic [5:0] OFS_SEL = 6'h00;
  localparam logic [5:0] OFS_LVL1 = 6'h04;
  localparam logic [5:0] OFS_WID1 = 6'h08;
  localparam logic [5:0] OFS_LVL2 = 6'h0c;
  localparam logic [5:0] OFS_WID2 = 6'h10;
  localparam logic [5:0] OFS_TQ_LVL = 6'h14;
  localparam logic [5:0] OFS_TQ_TIME = 6'h18;
  localparam logic [5:0] OFS_TON = 6'h1c;
  localparam logic [5:0] OFS_TOFF = 6'h20;
  localparam logic [5:0] OFS_CTRL = 6'h24;
  localparam logic [5:0] OFS_UV_LVL = 6'h28;
  localparam logic [5:0] OFS_STATUS = 6'h2c;
  localparam logic [7:0] SEL_RST = 8'h0f;
  localparam int unsigned CLK_NS = 10;
  localparam int unsigned TICK_NS = 1000000;
  localparam int unsigned TICK_CYC = TICK_NS / CLK_NS;
  localparam int unsigned LOSS_WIN_S_MS = 400;
  localparam logic [15:0] LOSS_WIN_TICKS = 16'(LOSS_WIN_S_MS);
  localparam logic [3:0] HYS_DIV = 4'ha;
  localparam logic [3:0] LOSS_FRAC = 4'ha;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic signed [15:0] out_freq;
    logic signed [15:0] freq_ref;
    logic [15:0] out_current;
    logic [15:0] rated_current;
    logic [15:0] dc_bus_volts;
    logic ctrl_supply_low;
    logic softcharge_open;
    logic baseblock;
    logic fault_major;
    logic keypad_comm_fault_a;
    logic keypad_comm_fault_b;
    logic minor_fault;
    logic editing;
    logic running;
    logic ref_from_keypad;
    logic run_from_keypad;
    logic ref_analog;
    logic torque_under;
    logic braking_resistor_hot;
    logic braking_transistor_fault;
    logic reset_active;
  } dso_drive_type;

  typedef struct packed {
    logic [2:0] sync;
    logic tmr_in;
    logic [NUM_OUT-1:0][7:0] sel;
    logic [15:0] lvl1;
    logic [15:0] wid1;
    logic [15:0] lvl2;
    logic [15:0] wid2;
    logic [15:0] tq_lvl;
    logic [15:0] tq_time;
    logic [15:0] ton;
    logic [15:0] toff;
    logic [15:0] uv_lvl;
    logic rws;
    logic ack;
    logic [31:0] rdata;
    logic [16:0] tick_cnt;
    logic [3:0] fd;
    logic tq_hit;
    logic tq_det;
    logic [15:0] tq_cnt;
    logic tmr_out;
    logic [15:0] tmr_cnt;
    logic [15:0] win_cnt;
    logic [15:0] ref_old;
    logic loss;
    logic [NUM_OUT-1:0] contact;
  } dso_state_type;

  localparam dso_state_type STATE_RST = '{sel: {NUM_OUT{SEL_RST}}, default: '0};
endpackage

// [dso_output_selector.sv]
// The Avalon-MM register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module dso_output_selector
  import dso_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire dso_drive_type drive,
  input wire logic timer_input,
  output logic [NUM_OUT-1:0] contact
);
  dso_state_type s_q;
  dso_state_type s_d;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] mag(input logic [15:0] v);
    mag = v[15] ? 16'(-v) : v;
  endfunction

  function automatic logic [15:0] adiff(input logic [15:0] a, input logic [15:0] b);
    adiff = (a > b) ? 16'(a - b) : 16'(b - a);
  endfunction

  // Closed at or below lvl, opens once at or above lvl plus width
  function automatic logic low_det(input logic cur, input logic [15:0] m,
                                   input logic [15:0] lvl, input logic [15:0] w);
    if (m <= lvl) begin
      low_det = 1'b1;
    end else if (17'(m) >= 17'(lvl) + 17'(w)) begin
      low_det = 1'b0;
    end else begin
      low_det = cur;
    end
  endfunction

  // Closed at or above lvl, releases at or below lvl minus width
  function automatic logic high_det(input logic cur, input logic [15:0] m,
                                    input logic [15:0] lvl, input logic [15:0] w);
    if (m >= lvl) begin
      high_det = 1'b1;
    end else if (17'(m) + 17'(w) <= 17'(lvl)) begin
      high_det = 1'b0;
    end else begin
      high_det = cur;
    end
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        merge[8*b +: 8] = nw[8*b +: 8];
      end
    end
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic tick;
    logic [15:0] fm;
    logic [15:0] rm;
    logic [15:0] l2m;
    logic dir_f;
    logic dir_r;
    logic [15:0] hys;
    logic [31:0] cond;
    logic [31:0] wr;
    logic [15:0] dly;
    logic [19:0] ref10;
    tick = 1'b0;
    fm = mag(drive.out_freq);
    rm = mag(drive.freq_ref);
    l2m = mag(s_q.lvl2);
    dir_f = (drive.out_freq[15] == s_q.lvl2[15]) || (drive.out_freq == 16'h0000);
    dir_r = (drive.freq_ref[15] == s_q.lvl2[15]) || (drive.freq_ref == 16'h0000);
    hys = 16'(drive.rated_current / 16'(HYS_DIV));
    cond = '0;
    wr = '0;
    dly = '0;
    ref10 = 20'(rm) * 20'(LOSS_FRAC);
    s_d = s_q;

    // Timer input pin: three stages, change taken once the last two agree
    s_d.sync = {s_q.sync[1:0], timer_input};
    if (s_q.sync[2] == s_q.sync[1]) begin
      s_d.tmr_in = s_q.sync[2];
    end

    // Millisecond tick
    if (s_q.tick_cnt == 17'(TICK_CYCLES - 1)) begin
      s_d.tick_cnt = '0;
      tick = 1'b1;
    end else begin
      s_d.tick_cnt = 17'(s_q.tick_cnt + 17'h00001);
    end

    // ****************************************
    // Frequency detectors
    // ****************************************
    s_d.fd[0] = low_det(s_q.fd[0], fm, s_q.lvl1, s_q.wid1);
    s_d.fd[1] = high_det(s_q.fd[1], fm, s_q.lvl1, s_q.wid1);
    s_d.fd[2] = dir_f & low_det(s_q.fd[2], fm, l2m, s_q.wid2);
    s_d.fd[3] = dir_f & high_det(s_q.fd[3], fm, l2m, s_q.wid2);

    // ****************************************
    // Torque detection
    // ****************************************
    if (!drive.torque_under) begin
      if (drive.out_current > s_q.tq_lvl) begin
        s_d.tq_hit = 1'b1;
      end else if (17'(drive.out_current) + 17'(hys) <= 17'(s_q.tq_lvl)) begin
        s_d.tq_hit = 1'b0;
      end
    end else begin
      if (drive.out_current < s_q.tq_lvl) begin
        s_d.tq_hit = 1'b1;
      end else if (17'(drive.out_current) >= 17'(s_q.tq_lvl) + 17'(hys)) begin
        s_d.tq_hit = 1'b0;
      end
    end
    if (!s_q.tq_hit) begin
      s_d.tq_cnt = '0;
      s_d.tq_det = 1'b0;
    end else if (s_q.tq_cnt >= s_q.tq_time) begin
      s_d.tq_det = 1'b1;
    end else if (tick) begin
      s_d.tq_cnt = 16'(s_q.tq_cnt + 16'h0001);
    end

    // ****************************************
    // On/off delay timer
    // ****************************************
    dly = s_q.tmr_in ? s_q.ton : s_q.toff;
    if (s_q.tmr_in == s_q.tmr_out) begin
      s_d.tmr_cnt = '0;
    end else if (s_q.tmr_cnt >= dly) begin
      s_d.tmr_out = s_q.tmr_in;
      s_d.tmr_cnt = '0;
    end else if (tick) begin
      s_d.tmr_cnt = 16'(s_q.tmr_cnt + 16'h0001);
    end

    // ****************************************
    // Reference loss
    // ****************************************
    if (tick) begin
      if (s_q.win_cnt == 16'(LOSS_WIN_TICKS - 16'h0001)) begin
        s_d.win_cnt = '0;
        s_d.ref_old = rm;
      end else begin
        s_d.win_cnt = 16'(s_q.win_cnt + 16'h0001);
      end
    end
    if (!drive.ref_analog) begin
      s_d.loss = 1'b0;
    end else if (s_q.ref_old != 16'h0000 && ref10 <= 20'(s_q.ref_old)) begin
      s_d.loss = 1'b1;
    end

    // ****************************************
    // Conditions by selection code
    // ****************************************
    cond[4] = s_q.fd[0];
    cond[5] = s_q.fd[1];
    cond[6] = !(drive.fault_major | drive.keypad_comm_fault_a | drive.keypad_comm_fault_b)
              && (!drive.editing || (s_q.rws && drive.running));
    cond[7] = (drive.dc_bus_volts < s_q.uv_lvl) | drive.ctrl_supply_low
              | drive.softcharge_open;
    cond[8] = drive.baseblock;
    cond[9] = drive.ref_from_keypad;
    cond[10] = drive.run_from_keypad;
    cond[11] = s_q.tq_det;
    cond[12] = s_q.loss;
    cond[13] = drive.braking_resistor_hot | drive.braking_transistor_fault;
    cond[14] = drive.fault_major;
    cond[15] = 1'b0;
    cond[16] = drive.minor_fault;
    cond[17] = drive.reset_active;
    cond[18] = s_q.tmr_out;
    cond[19] = adiff(fm, rm) <= s_q.wid2;
    cond[20] = dir_f && dir_r && adiff(fm, l2m) <= s_q.wid2
               && adiff(rm, l2m) <= s_q.wid2;
    cond[21] = s_q.fd[2];
    cond[22] = s_q.fd[3];
    cond[23] = !s_q.tq_det;
    for (int i = 0; i < NUM_OUT; i++) begin
      s_d.contact[i] = (s_q.sel[i] < 8'h20) ? cond[s_q.sel[i][4:0]] : 1'b0;
    end

    // ****************************************
    // Register bus
    // ****************************************
    s_d.ack = (avs_read | avs_write) & !s_q.ack;
    if (avs_read && !s_q.ack) begin
      unique case (avs_address)
        OFS_SEL: s_d.rdata = 32'(s_q.sel);
        OFS_LVL1: s_d.rdata = {16'h0000, s_q.lvl1};
        OFS_WID1: s_d.rdata = {16'h0000, s_q.wid1};
        OFS_LVL2: s_d.rdata = {16'h0000, s_q.lvl2};
        OFS_WID2: s_d.rdata = {16'h0000, s_q.wid2};
        OFS_TQ_LVL: s_d.rdata = {16'h0000, s_q.tq_lvl};
        OFS_TQ_TIME: s_d.rdata = {16'h0000, s_q.tq_time};
        OFS_TON: s_d.rdata = {16'h0000, s_q.ton};
        OFS_TOFF: s_d.rdata = {16'h0000, s_q.toff};
        OFS_CTRL: s_d.rdata = {31'h00000000, s_q.rws};
        OFS_UV_LVL: s_d.rdata = {16'h0000, s_q.uv_lvl};
        OFS_STATUS: s_d.rdata = 32'({s_q.tmr_in, s_q.tmr_out, s_q.loss, s_q.tq_det, s_q.fd, s_q.contact});
        default: s_d.rdata = '0;
      endcase
    end
    if (avs_write && s_q.ack) begin
      unique case (avs_address)
        OFS_SEL: begin
          wr = merge(32'(s_q.sel), avs_writedata, avs_byteenable);
          s_d.sel = wr[8*NUM_OUT-1:0];
        end
        OFS_LVL1: begin
          wr = merge({16'h0000, s_q.lvl1}, avs_writedata, avs_byteenable);
          s_d.lvl1 = wr[15:0];
        end
        OFS_WID1: begin
          wr = merge({16'h0000, s_q.wid1}, avs_writedata, avs_byteenable);
          s_d.wid1 = wr[15:0];
        end
        OFS_LVL2: begin
          wr = merge({16'h0000, s_q.lvl2}, avs_writedata, avs_byteenable);
          s_d.lvl2 = wr[15:0];
        end
        OFS_WID2: begin
          wr = merge({16'h0000, s_q.wid2}, avs_writedata, avs_byteenable);
          s_d.wid2 = wr[15:0];
        end
        OFS_TQ_LVL: begin
          wr = merge({16'h0000, s_q.tq_lvl}, avs_writedata, avs_byteenable);
          s_d.tq_lvl = wr[15:0];
        end
        OFS_TQ_TIME: begin
          wr = merge({16'h0000, s_q.tq_time}, avs_writedata, avs_byteenable);
          s_d.tq_time = wr[15:0];
        end
        OFS_TON: begin
          wr = merge({16'h0000, s_q.ton}, avs_writedata, avs_byteenable);
          s_d.ton = wr[15:0];
        end
        OFS_TOFF: begin
          wr = merge({16'h0000, s_q.toff}, avs_writedata, avs_byteenable);
          s_d.toff = wr[15:0];
        end
        OFS_CTRL: begin
          if (avs_byteenable[0]) begin
            s_d.rws = avs_writedata[0];
          end
        end
        OFS_UV_LVL: begin
          wr = merge({16'h0000, s_q.uv_lvl}, avs_writedata, avs_byteenable);
          s_d.uv_lvl = wr[15:0];
        end
        default: begin
          wr = '0;
        end
      endcase
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= STATE_RST;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & !s_q.ack;
  assign avs_readdata = s_q.rdata;
  assign contact = s_q.contact;
endmodule
`default_nettype wire

// [dso_output_selector_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module dso_output_selector_chk
  import dso_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire dso_drive_type drive,
  input wire logic [NUM_OUT-1:0] contact
);
  logic [NUM_OUT-1:0][7:0] sel_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Shadow of the selection codes, taken at the accepting edge of a write
  always_ff @(posedge clk) begin
    if (rst) begin
      sel_q <= {NUM_OUT{SEL_RST}};
    end else if (ce && avs_write && !avs_waitrequest && avs_address == OFS_SEL) begin
      for (int i = 0; i < NUM_OUT; i++) begin
        if (avs_byteenable[i]) begin
          sel_q[i] <= avs_writedata[8*i +: 8];
        end
      end
    end
  end
  a_bus_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest raised without a request");
  a_bus_one_wait: assert property (ce && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer not after one wait cycle");
  for (genvar g = 0; g < NUM_OUT; g++) begin : g_out
    a_inhibit_follow: assert property (ce && sel_q[g] == 8'h08 |=> contact[g] == $past(drive.baseblock))
      else $error("baseblock output wrong");
    a_keypad_ref: assert property (ce && sel_q[g] == 8'h09 |=> contact[g] == $past(drive.ref_from_keypad))
      else $error("keypad reference output wrong");
    a_keypad_run: assert property (ce && sel_q[g] == 8'h0a |=> contact[g] == $past(drive.run_from_keypad))
      else $error("keypad run output wrong");
    a_braking_fault: assert property (ce && sel_q[g] == 8'h0d |=>
      contact[g] == $past(drive.braking_resistor_hot || drive.braking_transistor_fault))
      else $error("braking fault output wrong");
    a_major_only: assert property (ce && sel_q[g] == 8'h0e |=> contact[g] == $past(drive.fault_major))
      else $error("major fault output wrong");
    a_unused_open: assert property (ce && sel_q[g] == 8'h0f |=> !contact[g])
      else $error("unused output closed");
    a_minor_follow: assert property (ce && sel_q[g] == 8'h10 |=> contact[g] == $past(drive.minor_fault))
      else $error("minor fault output wrong");
    a_reset_follow: assert property (ce && sel_q[g] == 8'h11 |=> contact[g] == $past(drive.reset_active))
      else $error("reset active output wrong");
  end
endmodule
bind dso_output_selector dso_output_selector_chk u_chk (.clk(clk), .rst(rst), .ce(ce),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest), .drive(drive), .contact(contact));
`default_nettype wire

// [dso_ext_equipment.sv]
`timescale 1ns/1ps
`default_nettype none
module dso_ext_equipment
  import dso_pkg::*;
(
  input wire logic clk,
  input wire logic close_req,
  input wire logic [NUM_OUT-1:0] contact,
  output logic timer_input,
  output logic [NUM_OUT-1:0] sensed
);
  // Switch on the timer input and relay inputs that read the contacts
  always_ff @(posedge clk) begin
    timer_input <= close_req;
    sensed <= contact;
  end
endmodule
`default_nettype wire

// [drive_status_output_selector_test.sv]
`timescale 1ns/1ps
`default_nettype none
module drive_status_output_selector_test
  import dso_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  dso_drive_type drv = '0;
  logic tmr_req = 1'b0;
  logic timer_input;
  logic [NUM_OUT-1:0] contact;
  logic [NUM_OUT-1:0] sensed;
  int checked = 0;
  int miscompares = 0;
  logic [15:0] ftab [9] = '{16'd0, 16'd100, 16'd119, 16'd120, 16'd100, 16'd81, 16'd80, 16'hff88, 16'hffb0};
  logic [2:0] etab [9] = '{3'b001, 3'b011, 3'b011, 3'b010, 3'b011, 3'b011, 3'b001, 3'b110, 3'b101};
  always #5 clk = ~clk;
  dso_output_selector #(.TICK_CYCLES(4)) u_dut (.clk(clk), .rst(rst), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .drive(drv), .timer_input(timer_input),
    .contact(contact));
  dso_ext_equipment u_ext (.clk(clk), .close_req(tmr_req), .contact(contact), .timer_input(timer_input),
    .sensed(sensed));
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic is_wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= is_wr;
    avs_read <= !is_wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      n++;
      @(posedge clk);
    end
    if (n == 50) begin
      miscompares++;
      $display("BAD bus answer expected %h seen %h", 1'b0, avs_waitrequest);
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input string what, input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(what, exp, q);
  endtask
  // Select codes, apply a drive state and compare the contacts once the path has settled
  task automatic cond(input logic [31:0] sel, input logic [79:0] hi, input logic [15:0] fl, input logic [2:0] exp);
    wr(OFS_SEL, sel);
    drv <= {hi, fl};
    repeat (4) @(posedge clk);
    check("contact", {29'h0, exp}, {29'h0, contact});
    check("sensed", {29'h0, exp}, {29'h0, sensed});
  endtask
  task automatic wait_check(input int n, input logic [2:0] exp);
    repeat (n) @(posedge clk);
    check("timed contact", {29'h0, exp}, {29'h0, contact});
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd("select reset", OFS_SEL, 32'h000f0f0f);
    rd("level reset", OFS_LVL2, 32'h0);
    rd("unmapped", 6'h30, 32'h0);
    wr(6'h30, 32'hffffffff);
    rd("unmapped after write", 6'h30, 32'h0);
    rd("select kept", OFS_SEL, 32'h000f0f0f);
    cond(32'h000f0f0f, 80'h0, 16'hffff, 3'b000);
    cond(32'h00110e08, 80'h0, 16'h2000, 3'b001);
    // Clock enable low freezes the contacts
    ce <= 1'b0;
    drv <= {80'h0, 16'h1000};
    wait_check(4, 3'b001);
    ce <= 1'b1;
    wait_check(3, 3'b010);
    cond(32'h00110e08, 80'h0, 16'h1000, 3'b010);
    cond(32'h00110e08, 80'h0, 16'h0e00, 3'b000);
    cond(32'h00110e08, 80'h0, 16'h0001, 3'b100);
    cond(32'h000a0910, 80'h0, 16'h0200, 3'b001);
    cond(32'h000a0910, 80'h0, 16'h0040, 3'b010);
    cond(32'h000a0910, 80'h0, 16'h0020, 3'b100);
    cond(32'h0006070d, 80'h0, 16'h0004, 3'b101);
    cond(32'h0006070d, 80'h0, 16'h0002, 3'b101);
    cond(32'h0006070d, 80'h0, 16'h8000, 3'b110);
    cond(32'h0006070d, 80'h0, 16'h4000, 3'b110);
    cond(32'h0006070d, 80'h0, 16'h0180, 3'b000);
    wr(OFS_CTRL, 32'h1);
    cond(32'h0006070d, 80'h0, 16'h0180, 3'b100);
    cond(32'h0006070d, 80'h0, 16'h1000, 3'b000);
    wr(OFS_UV_LVL, 32'd100);
    cond(32'h0006070d, 80'h0, 16'h0000, 3'b110);
    wr(OFS_LVL1, 32'd100);
    wr(OFS_WID1, 32'd20);
    wr(OFS_LVL2, 32'h0000ffce);
    wr(OFS_WID2, 32'd10);
    for (int i = 0; i < 9; i++) begin
      cond(32'h00160504, {ftab[i], 64'h0}, 16'h0, etab[i]);
    end
    rd("level 2", OFS_LVL2, 32'h0000ffce);
    cond(32'h00141315, {16'hffc9, 16'hffce, 48'h0}, 16'h0, 3'b110);
    cond(32'h00141315, {16'hffce, 16'hffce, 48'h0}, 16'h0, 3'b111);
    cond(32'h00141315, {16'hffc5, 16'hffb0, 48'h0}, 16'h0, 3'b001);
    cond(32'h00141315, {16'h0032, 16'h0032, 48'h0}, 16'h0, 3'b010);
    wr(OFS_TQ_LVL, 32'd100);
    wr(OFS_TQ_TIME, 32'd3);
    cond(32'h00000b17, 80'h0, 16'h0, 3'b001);
    cond(32'h00000b17, {32'h0, 16'd200, 16'd100, 16'h0}, 16'h0, 3'b001);
    wait_check(30, 3'b010);
    drv <= {32'h0, 16'd0, 16'd100, 16'h0, 16'h0000};
    wait_check(5, 3'b001);
    // Under-current mode with a hysteresis of a tenth of rated current
    drv <= {32'h0, 16'd50, 16'd100, 16'h0, 16'h0008};
    wait_check(30, 3'b010);
    drv <= {32'h0, 16'd105, 16'd100, 16'h0, 16'h0008};
    wait_check(5, 3'b010);
    drv <= {32'h0, 16'd110, 16'd100, 16'h0, 16'h0008};
    wait_check(5, 3'b001);
    // Analog reference drop to a tenth inside one loss window
    cond(32'h0000000c, {16'h0, 16'd1000, 48'h0}, 16'h0010, 3'b000);
    wait_check(1700, 3'b000);
    drv <= {16'h0, 16'd100, 48'h0, 16'h0010};
    wait_check(4, 3'b001);
    drv <= {16'h0, 16'd100, 48'h0, 16'h0000};
    wait_check(4, 3'b000);
    wr(OFS_TON, 32'd3);
    wr(OFS_TOFF, 32'd2);
    cond(32'h00000012, 80'h0, 16'h0, 3'b000);
    tmr_req <= 1'b1;
    wait_check(6, 3'b000);
    wait_check(30, 3'b001);
    tmr_req <= 1'b0;
    wait_check(4, 3'b001);
    wait_check(30, 3'b000);
    rd("status", OFS_STATUS, 32'h00000028);
    end_of_test();
  end
endmodule
`default_nettype wire
